//--- uie_pkg.sv
// Register map, field positions and reset values of the USB interrupt block
package uie_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_IRQ_EN = 8'h00;
   localparam logic [7:0] OFS_ERR_STAT = 8'h04;
   localparam logic [7:0] OFS_ERR_MASK = 8'h08;
   localparam logic [7:0] OFS_EVT_STAT = 8'h0C;
   localparam logic [7:0] OFS_MODE = 8'h10;
   // Enable and event status bit positions
   localparam int BIT_STALL = 7;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_RESUME = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_TOKEN = 3;
   localparam int BIT_SOF = 2;
   localparam int BIT_ERR = 1;
   localparam int BIT_RST_DET = 0;
   // Error status bit positions
   localparam int EBIT_STUFF = 7;
   localparam int EBIT_OVERRUN = 5;
   localparam int EBIT_TURN = 4;
   localparam int EBIT_FIELD = 3;
   localparam int EBIT_CRC16 = 2;
   localparam int EBIT_CRC5_EOF = 1;
   localparam int EBIT_PID = 0;
   // Mode register bit
   localparam int MBIT_HOST = 0;
   // Reset values and implemented-bit masks
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] ERR_MASK_RESET = 8'h00;
   localparam logic [7:0] EVT_RESET = 8'h00;
   localparam logic MODE_RESET = 1'b0;
   localparam logic [7:0] ERR_IMPL = 8'hBF;
   localparam logic [7:0] IE_HOST_IMPL = 8'hFF;
   localparam logic [7:0] IE_DEV_IMPL = 8'hBF;
   // Buffer descriptor byte count width
   localparam int BC_W = 10;
   typedef enum {UIE_RX_IDLE, UIE_RX_STORE, UIE_RX_DISCARD} uie_rx_state_t;
endpackage : uie_pkg

//--- uie_sticky8.sv
// Eight sticky flags, set by hardware, cleared by writing one
module uie_sticky8
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] reset_val,
   input wire logic [7:0] impl,
   input wire logic [7:0] set_evt,
   input wire logic [7:0] clr,
   output logic [7:0] flags
);
   logic [7:0] next_flags;

   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_bit
         // Set wins over a clear in the same cycle so no event is lost
         assign next_flags[i] = impl[i] & (set_evt[i] | (flags[i] & ~clr[i]));
      end
   endgenerate

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         flags <= reset_val;
      else
         flags <= next_flags;
   end
endmodule : uie_sticky8

//--- uie_top.sv
// USB interrupt enable, event status and error flag registers
// How it works
// - Enable bits gate the eight top interrupts
// - Bit 1 gates the summary error interrupt
// - Attach enable exists only in host mode
// - Bit 0 gates bus reset or detach
// - Upper three bytes and error bit 6 read zero
// - Bit stuff violation sets error bit 7
// - Overlong packet sets bit 5, excess dropped
// - Turnaround timer expiry sets error bit 4
// - Partial-byte data field sets error bit 3
// - Failed CRC16 sets bit 2, pass doesn't
// - Device mode token CRC5 failure sets bit 1
// - Host mode end-of-frame overrun sets bit 1
// - Failed PID check sets error bit 0
// - Writing one clears a flag, zero keeps
// - Flags stay set until software clears them; attach flag also clears on leaving host mode
// - Summary error only from enabled error flags
module uie_top
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic stall_evt,
   input wire logic attach_evt,
   input wire logic resume_evt,
   input wire logic idle_evt,
   input wire logic token_done_evt,
   input wire logic frame_start_evt,
   input wire logic bus_reset_evt,
   input wire logic detach_evt,
   input wire logic stuffing_error_evt,
   input wire logic turnaround_expired,
   input wire logic crc16_check_done,
   input wire logic crc16_pass,
   input wire logic token_crc5_fail,
   input wire logic frame_end_overrun,
   input wire logic pid_check_fail,
   input wire logic rx_pkt_start,
   input wire logic rx_pkt_end,
   input wire logic [2:0] rx_bit_residue,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic [uie_pkg::BC_W-1:0] buffer_descriptor_count,
   output logic store_valid,
   output logic [7:0] store_data,
   output logic host_mode,
   output logic summary_error_irq_flag,
   output logic irq
);
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction : hit

   // A one in the written byte clears, a zero keeps
   function automatic logic [7:0] w1c(input logic strobe,
                                      input logic [7:0] data);
      w1c = strobe ? data : 8'h00;
   endfunction : w1c

   logic [7:0] usb_interrupt_enable;
   logic [7:0] usb_error_enable_mask;
   logic [7:0] usb_error_flag_status;
   logic [7:0] evt_status;
   logic rd_load;
   logic wr_low;
   logic overrun_evt;
   logic [uie_pkg::BC_W-1:0] rx_count;
   uie_pkg::uie_rx_state_t rx_state;
   uie_pkg::uie_rx_state_t next_rx_state;

   uie_wb_slave u_bus
   (
      .mclk(mclk),
      .nrst(nrst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i),
      .wb_ack_o(wb_ack_o),
      .rd_load(rd_load),
      .wr_low(wr_low)
   );

   // Address decode
   wire sel_ie = hit(wb_adr_i, uie_pkg::OFS_IRQ_EN);
   wire sel_err = hit(wb_adr_i, uie_pkg::OFS_ERR_STAT);
   wire sel_mask = hit(wb_adr_i, uie_pkg::OFS_ERR_MASK);
   wire sel_evt = hit(wb_adr_i, uie_pkg::OFS_EVT_STAT);
   wire sel_mode = hit(wb_adr_i, uie_pkg::OFS_MODE);
   wire [7:0] wlo = wb_dat_i[7:0];

   // Write strobes, taken on the edge where the master sees ack
   wire wr_ie = wr_low & sel_ie;
   wire wr_err = wr_low & sel_err;
   wire wr_mask = wr_low & sel_mask;
   wire wr_evt = wr_low & sel_evt;
   wire wr_mode = wr_low & sel_mode;

   // Attach enable is unimplemented in device mode
   wire [7:0] ie_impl = host_mode ? uie_pkg::IE_HOST_IMPL
                                  : uie_pkg::IE_DEV_IMPL;
   wire [7:0] ie_eff = usb_interrupt_enable & ie_impl;

   // Named enable fields
   wire stall_irq_en = ie_eff[uie_pkg::BIT_STALL];
   wire attach_irq_en = ie_eff[uie_pkg::BIT_ATTACH];
   wire resume_irq_en = ie_eff[uie_pkg::BIT_RESUME];
   wire idle_irq_en = ie_eff[uie_pkg::BIT_IDLE];
   wire token_done_irq_en = ie_eff[uie_pkg::BIT_TOKEN];
   wire frame_start_irq_en = ie_eff[uie_pkg::BIT_SOF];
   wire error_irq_en = ie_eff[uie_pkg::BIT_ERR];
   // Bit 0 is one flop with a meaning per mode
   wire bus_reset_irq_en = ie_eff[uie_pkg::BIT_RST_DET] & ~host_mode;
   wire detach_irq_en = ie_eff[uie_pkg::BIT_RST_DET] & host_mode;
   wire [7:0] ie_read = {stall_irq_en, attach_irq_en, resume_irq_en,
                         idle_irq_en, token_done_irq_en, frame_start_irq_en,
                         error_irq_en, bus_reset_irq_en | detach_irq_en};

   // Level interrupt from the enabled sticky events
   wire [7:0] irq_src = evt_status & ie_read;
   wire irq_any = |irq_src;

   // Clear strobes; a one clears, a zero keeps
   wire [7:0] err_clr = w1c(wr_err, wlo);
   wire [7:0] evt_clr = w1c(wr_evt, wlo);

   // Unmasked error flags drive the summary error event
   wire err_hit = |(usb_error_flag_status & usb_error_enable_mask);

   // Bit 1 of the error flags changes meaning with the mode
   wire crc5_or_eof = host_mode ? frame_end_overrun
                                : token_crc5_fail;
   // Bit 0 event is bus reset as device, detach as host
   wire rst_or_det = host_mode ? detach_evt : bus_reset_evt;

   // Error event vector
   wire [7:0] err_set;
   assign err_set[uie_pkg::EBIT_STUFF] = stuffing_error_evt;
   assign err_set[6] = 1'b0;
   assign err_set[uie_pkg::EBIT_OVERRUN] = overrun_evt;
   assign err_set[uie_pkg::EBIT_TURN] = turnaround_expired;
   assign err_set[uie_pkg::EBIT_FIELD] =
      rx_pkt_end & (rx_bit_residue != 3'h0);
   assign err_set[uie_pkg::EBIT_CRC16] =
      crc16_check_done & ~crc16_pass;
   assign err_set[uie_pkg::EBIT_CRC5_EOF] = crc5_or_eof;
   assign err_set[uie_pkg::EBIT_PID] = pid_check_fail;

   // Top-level event vector
   wire [7:0] evt_set;
   assign evt_set[uie_pkg::BIT_STALL] = stall_evt;
   assign evt_set[uie_pkg::BIT_ATTACH] = attach_evt & host_mode;
   assign evt_set[uie_pkg::BIT_RESUME] = resume_evt;
   assign evt_set[uie_pkg::BIT_IDLE] = idle_evt;
   assign evt_set[uie_pkg::BIT_TOKEN] = token_done_evt;
   assign evt_set[uie_pkg::BIT_SOF] = frame_start_evt;
   assign evt_set[uie_pkg::BIT_ERR] = err_hit;
   assign evt_set[uie_pkg::BIT_RST_DET] = rst_or_det;

   // Sticky flags hold until cleared by software; the attach event flag also clears on leaving host mode
   uie_sticky8 u_err
   (
      .mclk(mclk),
      .nrst(nrst),
      .reset_val(uie_pkg::ERR_RESET),
      .impl(uie_pkg::ERR_IMPL),
      .set_evt(err_set),
      .clr(err_clr),
      .flags(usb_error_flag_status)
   );

   uie_sticky8 u_evt
   (
      .mclk(mclk),
      .nrst(nrst),
      .reset_val(uie_pkg::EVT_RESET),
      .impl(ie_impl),
      .set_evt(evt_set),
      .clr(evt_clr),
      .flags(evt_status)
   );

   // Named error flag fields; bit 1 is named per mode
   wire stuffing_error_flag = usb_error_flag_status[uie_pkg::EBIT_STUFF];
   wire buffer_overrun_flag = usb_error_flag_status[uie_pkg::EBIT_OVERRUN];
   wire turnaround_timeout_flag = usb_error_flag_status[uie_pkg::EBIT_TURN];
   wire field_size_error_flag = usb_error_flag_status[uie_pkg::EBIT_FIELD];
   wire data_crc_fail_flag = usb_error_flag_status[uie_pkg::EBIT_CRC16];
   wire token_crc_fail_flag =
      usb_error_flag_status[uie_pkg::EBIT_CRC5_EOF] & ~host_mode;
   wire frame_end_error_flag =
      usb_error_flag_status[uie_pkg::EBIT_CRC5_EOF] & host_mode;
   wire pid_check_fail_flag = usb_error_flag_status[uie_pkg::EBIT_PID];
   wire [7:0] err_read = {stuffing_error_flag, 1'b0, buffer_overrun_flag,
                          turnaround_timeout_flag, field_size_error_flag,
                          data_crc_fail_flag,
                          token_crc_fail_flag | frame_end_error_flag,
                          pid_check_fail_flag};

   // Read multiplexer; upper bits and unmapped offsets read zero
   wire [7:0] rd_lo = sel_ie ? ie_read :
                      sel_err ? err_read :
                      sel_mask ? usb_error_enable_mask :
                      sel_evt ? evt_status :
                      sel_mode ? {7'h00, host_mode} : 8'h00;
   wire [31:0] rd_word = {24'h000000, rd_lo};

   // Receive length check against the buffer descriptor
   wire room = rx_count < buffer_descriptor_count;
   wire take_byte = (rx_state == uie_pkg::UIE_RX_STORE) & rx_byte_valid;

   always_comb
   begin
      next_rx_state = rx_state;
      overrun_evt = 1'b0;
      case (rx_state)
         uie_pkg::UIE_RX_IDLE:
         begin
            if (rx_pkt_start)
               next_rx_state = uie_pkg::UIE_RX_STORE;
         end
         uie_pkg::UIE_RX_STORE:
         begin
            if (rx_byte_valid & ~room)
            begin
               // Too many bytes: flag once and drop the rest
               overrun_evt = 1'b1;
               next_rx_state = uie_pkg::UIE_RX_DISCARD;
            end
            else if (rx_pkt_end)
               next_rx_state = uie_pkg::UIE_RX_IDLE;
         end
         uie_pkg::UIE_RX_DISCARD:
         begin
            if (rx_pkt_end)
               next_rx_state = uie_pkg::UIE_RX_IDLE;
         end
         default:
         begin
            next_rx_state = uie_pkg::UIE_RX_IDLE;
         end
      endcase
   end

   wire keep_byte = take_byte & room;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         rx_state <= uie_pkg::UIE_RX_IDLE;
      else
         rx_state <= next_rx_state;
   end

   // Count stops at the descriptor count, so it cannot wrap
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         rx_count <= '0;
      else if (rx_pkt_start)
         rx_count <= '0;
      else if (keep_byte)
         rx_count <= rx_count + 1'b1;
   end

   // Only bytes within the descriptor count reach the buffer
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         store_valid <= 1'b0;
      else
         store_valid <= keep_byte;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         store_data <= 8'h00;
      else if (keep_byte)
         store_data <= rx_byte;
   end

   // Software-written control registers
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         usb_interrupt_enable <= uie_pkg::IRQ_EN_RESET;
      else if (wr_ie)
         usb_interrupt_enable <= wlo & ie_impl;
      else
         // Leaving host mode drops a stale attach enable
         usb_interrupt_enable <= usb_interrupt_enable & ie_impl;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         usb_error_enable_mask <= uie_pkg::ERR_MASK_RESET;
      else if (wr_mask)
         usb_error_enable_mask <= wlo & uie_pkg::ERR_IMPL;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         host_mode <= uie_pkg::MODE_RESET;
      else if (wr_mode)
         host_mode <= wlo[uie_pkg::MBIT_HOST];
   end

   // Read data is registered and holds until the next read
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         wb_dat_o <= 32'h00000000;
      else if (rd_load)
         wb_dat_o <= rd_word;
   end

   // Interrupt levels come from flops, one cycle behind the flags
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         summary_error_irq_flag <= 1'b0;
      else
         summary_error_irq_flag <= err_hit;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= irq_any;
   end
endmodule : uie_top

//--- uie_top_sva.sv
// Concurrent checks on the ports of the USB interrupt register block
module uie_top_sva
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic store_valid,
   input wire logic [7:0] store_data,
   input wire logic host_mode,
   input wire logic summary_error_irq_flag,
   input wire logic irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   wire logic rd_ack = wb_ack_o && !wb_we_i;
   a_ack_follows_req:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_upper_byte_zero:
      assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_err_bit6_zero:
      assert property (rd_ack && wb_adr_i[7:2] == 6'h01 |-> !wb_dat_o[6])
      else $error("error status bit 6 reads one");
   a_attach_dev_zero:
      assert property (rd_ack && wb_adr_i[7:2] == 6'h00 && !host_mode
         |-> !wb_dat_o[6])
      else $error("attach enable set in device mode");
   a_unmapped_zero:
      assert property (rd_ack && wb_adr_i > 8'h13 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_reset_quiet:
      assert property ($rose(nrst) |-> !irq && !summary_error_irq_flag
         && !host_mode && !store_valid)
      else $error("outputs not clear after reset");
   a_store_cause:
      assert property (store_valid |-> $past(rx_byte_valid)
         && store_data == $past(rx_byte))
      else $error("stored byte without matching input");
   cover property (rd_ack && wb_dat_o != 32'h0);
   cover property (store_valid);
   cover property (summary_error_irq_flag && irq);
endmodule : uie_top_sva

bind uie_top uie_top_sva u_sva (.*);

//--- uie_top_tb.sv
// Self-checking bench for the USB interrupt register block
module uie_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] bsel = 4'hF;
   logic [7:0] gv = 8'h00;
   logic [6:0] er = 7'h00;
   wire stall_evt, attach_evt, resume_evt, idle_evt, token_done_evt;
   wire frame_start_evt, bus_reset_evt, detach_evt, stuffing_error_evt;
   wire turnaround_expired, crc16_check_done, crc16_pass;
   wire token_crc5_fail, frame_end_overrun, pid_check_fail;
   logic rx_pkt_start = 1'b0;
   logic rx_pkt_end = 1'b0;
   logic [2:0] rx_bit_residue = 3'h0;
   logic rx_byte_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic [uie_pkg::BC_W-1:0] buffer_descriptor_count = '0;
   logic store_valid, host_mode, summary_error_irq_flag, irq;
   logic [7:0] store_data;
   int errors = 0;
   int n_compared = 0;
   int nst = 0;
   logic [31:0] rs = 32'h91198DEE;
   logic [31:0] q;
   assign {stall_evt, attach_evt, resume_evt, idle_evt, token_done_evt,
      frame_start_evt, bus_reset_evt, detach_evt} = gv;
   assign {stuffing_error_evt, turnaround_expired, crc16_check_done,
      crc16_pass, token_crc5_fail, frame_end_overrun, pid_check_fail} = er;
   uie_top dut (.*);
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
      if (store_valid === 1'b1)
         nst++;
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd
   function automatic logic [7:0] eexp(input logic [6:0] p, input logic h);
      eexp = 8'h00;
      eexp[7] = p[6];
      eexp[4] = p[5];
      eexp[2] = p[4] & ~p[3];
      eexp[1] = h ? p[1] : p[2];
      eexp[0] = p[0];
   endfunction : eexp
   function automatic logic [7:0] gexp(input logic [7:0] g, input logic h,
      input logic s);
      gexp = g & 8'hBC;
      gexp[6] = g[6] & h;
      gexp[1] = s;
      gexp[0] = h ? g[0] : g[1];
   endfunction : gexp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= bsel;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
         @(posedge mclk);
      while (wb_ack_o !== 1'b1 && n++ < 50);
      chk(32'(n < 50), 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic pkt(input int k, input logic [2:0] r);
      @(posedge mclk);
      rx_pkt_start <= 1'b1;
      @(posedge mclk);
      rx_pkt_start <= 1'b0;
      repeat (k)
      begin
         rx_byte_valid <= 1'b1;
         rx_byte <= 8'(rnd());
         @(posedge mclk);
      end
      rx_byte_valid <= 1'b0;
      rx_bit_residue <= r;
      rx_pkt_end <= 1'b1;
      @(posedge mclk);
      rx_pkt_end <= 1'b0;
   endtask : pkt
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      #100000;
      errors++;
      final_report();
   end
   initial
   begin
      logic [31:0] d;
      logic [7:0] m, c, ee, ge, g;
      logic [6:0] p;
      logic [2:0] r;
      logic h;
      int k;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      for (int a = 0; a < 9; a++)
         rd(8'(a * 4), 32'h0);
      bus(1'b1, 8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      bsel = 4'hE;
      bus(1'b1, 8'h08, 32'hFF);
      bsel = 4'hF;
      rd(8'h08, 32'h0);
      er <= 7'h40;
      bus(1'b1, 8'h04, 32'hFF);
      er <= 7'h00;
      rd(8'h04, 32'h80);
      bus(1'b1, 8'h04, 32'hFF);
      rd(8'h04, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         h = i[0];
         m = 8'(rnd());
         g = 8'(rnd());
         p = 7'(rnd());
         bus(1'b1, 8'h10, 32'(h));
         bus(1'b1, 8'h08, 32'(m));
         chk(32'(host_mode), 32'(h));
         @(posedge mclk);
         gv <= g;
         er <= p;
         @(posedge mclk);
         gv <= 8'h00;
         er <= 7'h00;
         ee = eexp(p, h);
         rd(8'h04, 32'(ee));
         ge = gexp(g, h, |(ee & m));
         rd(8'h0C, 32'(ge));
         d = rnd();
         bus(1'b1, 8'h00, d);
         rd(8'h00, 32'(d[7:0] & (h ? 8'hFF : 8'hBF)));
         repeat (2) @(posedge mclk);
         chk(32'(irq), 32'(|(ge & d[7:0])));
         chk(32'(summary_error_irq_flag), 32'(|(ee & m)));
         c = 8'(rnd());
         bus(1'b1, 8'h04, 32'(c));
         rd(8'h04, 32'(ee & ~c));
         bus(1'b1, 8'h04, 32'hFF);
         bus(1'b1, 8'h0C, 32'hFF);
      end
      $display("test flags done");
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h00, 32'hFF);
      @(posedge mclk);
      gv <= 8'hFF;
      er <= 7'h7F;
      @(posedge mclk);
      gv <= 8'h00;
      er <= 7'h00;
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      for (int a = 0; a < 5; a++)
         rd(8'(a * 4), 32'h0);
      chk(32'(irq), 32'h0);
      $display("test midrun reset done");
      for (int i = 0; i < 4; i++)
      begin
         k = 1 + int'(rnd() % 6);
         buffer_descriptor_count <= k[uie_pkg::BC_W-1:0];
         r = i[1] ? 3'(rnd()) : 3'h0;
         nst = 0;
         pkt(k + 2 * (i % 2), r);
         ee = (i[0] ? 8'h20 : 8'h00) | (r != 0 ? 8'h08 : 8'h00);
         rd(8'h04, 32'(ee));
         chk(32'(nst), 32'(k));
         bus(1'b1, 8'h04, 32'hFF);
      end
      $display("test receive done");
      final_report();
   end
endmodule : uie_top_tb

//--- uie_wb_slave.sv
// Classic Wishbone handshake: one wait state, ack for one cycle
module uie_wb_slave
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   output logic wb_ack_o,
   output logic rd_load,
   output logic wr_low
);
   wire req = wb_cyc_i & wb_stb_i;

   // Read data is loaded on the edge that raises ack
   assign rd_load = req & ~wb_ack_o & ~wb_we_i;
   // Write lands on the edge where the master sees ack; low lane only
   assign wr_low = req & wb_ack_o & wb_we_i & wb_sel_i[0];

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req & ~wb_ack_o;
   end
endmodule : uie_wb_slave
